// ### common/bltr_params.svh
`ifndef BLTR_PARAMS_SVH
`define BLTR_PARAMS_SVH

// Word indices as printed; the plain register port addresses words directly
`define BLTR_ADDR_W 8
`define BLTR_OFF_CFG 8'hd0
`define BLTR_OFF_CTL 8'hd1
`define BLTR_OFF_STS 8'hd2
`define BLTR_OFF_BER 8'hd3

// Configuration word fields
`define BLTR_CFG_LO_MSB 15
`define BLTR_CFG_REM_OVR 16
`define BLTR_CFG_LOC_OVR 17
`define BLTR_CFG_RSV_MSB 19
`define BLTR_CFG_RSV_LSB 18
`define BLTR_CFG_CTLE_MSB 22
`define BLTR_CFG_CTLE_LSB 20
`define BLTR_CFG_SWING 23
`define BLTR_CFG_DFE_MSB 26
`define BLTR_CFG_DFE_LSB 24
`define BLTR_CFG_BIT27 27
`define BLTR_CFG_MAXM 28
`define BLTR_CFG_STEP_MSB 31
`define BLTR_CFG_STEP_LSB 29
// Reset: training enable and pass_one set, main step 2, pre/post step 1,
// hysteresis 2, local override 1, everything else 0
`define BLTR_CFG_RESET 32'h0002_2129

// Restart/update word strobe bits
`define BLTR_CTL_RESTART 0
`define BLTR_CTL_REM_UPD 4
`define BLTR_CTL_LOC_UPD 8

// Mode codes
`define BLTR_CTLE_OFF 3'h0
`define BLTR_CTLE_ON 3'h3
`define BLTR_DFE_OFF 3'h0
`define BLTR_DFE_END 3'h2
`define BLTR_DFE_STEPS 3'h3

// Measurement length field
`define BLTR_BER_MSB 9
`define BLTR_BER_W 10
`define BLTR_BER_RESET 10'h000

`endif

// ### common/bltr_pkg.sv
`include "bltr_params.svh"

package bltr_pkg;

    typedef enum logic [1:0] {
        BLTR_CTLE_DIS = 2'b00,
        BLTR_CTLE_EN = 2'b01,
        BLTR_CTLE_RSV = 2'b10
    } bltr_ctle_t;

    typedef enum logic [1:0] {
        BLTR_DFE_DIS = 2'b00,
        BLTR_DFE_AT_END = 2'b01,
        BLTR_DFE_AFTER_STEPS = 2'b10,
        BLTR_DFE_RSV = 2'b11
    } bltr_dfe_t;

    // Decoded controls handed to the training state machine
    typedef struct packed {
        logic [`BLTR_CFG_LO_MSB:0] low_fields;
        logic remote_coef_override_en;
        logic local_coef_override_en;
        bltr_ctle_t ctle_mode;
        logic swing_high;
        bltr_dfe_t dfe_mode;
        logic max_eq_mode;
        logic [2:0] max_post_steps;
        logic [`BLTR_BER_MSB:0] ber_frames;
    } bltr_ctrl_t;

    // One-cycle commands to the training state machine
    typedef struct packed {
        logic restart;
        logic send_remote;
        logic apply_local;
    } bltr_cmd_t;

    // Status levels from the training state machine
    typedef struct packed {
        logic ctle_tune_err;
        logic ctle_lock_loss;
        logic lock_err;
        logic ber_err;
        logic failure;
        logic running;
        logic frame_lock;
        logic rx_trained;
    } bltr_status_t;

endpackage : bltr_pkg

// ### logic/bltr_regs.sv
// Added by the designer: the strobed register port.
`include "bltr_params.svh"

module bltr_regs
    import bltr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`BLTR_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    // Training state machine side
    output bltr_ctrl_t ctrl,
    output bltr_cmd_t cmd,
    input wire bltr_status_t status_in
);

    logic [31:0] cfg_reg;
    logic [`BLTR_BER_MSB:0] ber_reg;
    bltr_cmd_t cmd_reg;
    logic [7:0] sts_meta_reg;
    logic [7:0] sts_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    function automatic logic hit(input logic [`BLTR_ADDR_W-1:0] a,
                                 input logic [`BLTR_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic bltr_ctle_t ctle_decode(input logic [2:0] code);
        case (code)
            `BLTR_CTLE_OFF: ctle_decode = BLTR_CTLE_DIS;
            `BLTR_CTLE_ON: ctle_decode = BLTR_CTLE_EN;
            default: ctle_decode = BLTR_CTLE_RSV;
        endcase
    endfunction : ctle_decode

    function automatic bltr_dfe_t dfe_decode(input logic [2:0] code);
        case (code)
            `BLTR_DFE_OFF: dfe_decode = BLTR_DFE_DIS;
            `BLTR_DFE_END: dfe_decode = BLTR_DFE_AT_END;
            `BLTR_DFE_STEPS: dfe_decode = BLTR_DFE_AFTER_STEPS;
            default: dfe_decode = BLTR_DFE_RSV;
        endcase
    endfunction : dfe_decode

    // Configuration word; reserved bits are stored as written so that a
    // read-modify-write returns them unchanged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= `BLTR_CFG_RESET;
        end else if (wr_en && hit(addr, `BLTR_OFF_CFG)) begin
            cfg_reg <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ber_reg <= `BLTR_BER_RESET;
        end else if (wr_en && hit(addr, `BLTR_OFF_BER)) begin
            ber_reg <= wdata[`BLTR_BER_MSB:0];
        end
    end

    // Strobes live one cycle; an update without its override is dropped,
    // since the training logic would otherwise fight software for the taps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= '0;
        end else begin
            cmd_reg <= '0;
            if (wr_en && hit(addr, `BLTR_OFF_CTL)) begin
                cmd_reg.restart <= wdata[`BLTR_CTL_RESTART];
                cmd_reg.send_remote <= wdata[`BLTR_CTL_REM_UPD]
                    && cfg_reg[`BLTR_CFG_REM_OVR];
                cmd_reg.apply_local <= wdata[`BLTR_CTL_LOC_UPD]
                    && cfg_reg[`BLTR_CFG_LOC_OVR];
            end
        end
    end

    // Status comes from the training clock area; two stages before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sts_meta_reg <= '0;
            sts_reg <= '0;
        end else begin
            sts_meta_reg <= status_in;
            sts_reg <= sts_meta_reg;
        end
    end

    always_comb begin
        rdata_next = '0;
        if (hit(addr, `BLTR_OFF_CFG)) begin
            rdata_next = cfg_reg;
        end else if (hit(addr, `BLTR_OFF_CTL)) begin
            rdata_next = '0;
        end else if (hit(addr, `BLTR_OFF_STS)) begin
            rdata_next = {24'h00_0000, sts_reg};
        end else if (hit(addr, `BLTR_OFF_BER)) begin
            rdata_next = {22'h00_0000, ber_reg};
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else if (rd_en) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign rdata = rdata_reg;
    assign cmd = cmd_reg;

    always_comb begin
        ctrl.low_fields = cfg_reg[`BLTR_CFG_LO_MSB:0];
        ctrl.remote_coef_override_en = cfg_reg[`BLTR_CFG_REM_OVR];
        ctrl.local_coef_override_en = cfg_reg[`BLTR_CFG_LOC_OVR];
        ctrl.ctle_mode = ctle_decode(cfg_reg[`BLTR_CFG_CTLE_MSB:`BLTR_CFG_CTLE_LSB]);
        ctrl.swing_high = cfg_reg[`BLTR_CFG_SWING];
        ctrl.dfe_mode = dfe_decode(cfg_reg[`BLTR_CFG_DFE_MSB:`BLTR_CFG_DFE_LSB]);
        ctrl.max_eq_mode = cfg_reg[`BLTR_CFG_MAXM];
        ctrl.max_post_steps = cfg_reg[`BLTR_CFG_STEP_MSB:`BLTR_CFG_STEP_LSB];
        ctrl.ber_frames = ber_reg;
    end

    // Views used only by the checks below
    logic [2:0] ctle_code;
    logic [2:0] dfe_code;
    bltr_status_t sts_view;
    bltr_status_t rd_view;

    assign ctle_code = cfg_reg[`BLTR_CFG_CTLE_MSB:`BLTR_CFG_CTLE_LSB];
    assign dfe_code = cfg_reg[`BLTR_CFG_DFE_MSB:`BLTR_CFG_DFE_LSB];
    assign sts_view = sts_reg;
    assign rd_view = rdata_reg[$bits(bltr_status_t)-1:0];

    default clocking regs_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ctl_write(int b);
        wr_en && hit(addr, `BLTR_OFF_CTL) && wdata[b];
    endsequence

    sequence s_ctl_clear(int b);
        wr_en && hit(addr, `BLTR_OFF_CTL) && !wdata[b];
    endsequence

    sequence s_cfg_write;
        wr_en && hit(addr, `BLTR_OFF_CFG);
    endsequence

    sequence s_cfg_read;
        rd_en && hit(addr, `BLTR_OFF_CFG);
    endsequence

    sequence s_ber_write;
        wr_en && hit(addr, `BLTR_OFF_BER);
    endsequence

    sequence s_ber_read;
        rd_en && hit(addr, `BLTR_OFF_BER);
    endsequence

    sequence s_sts_read;
        rd_en && hit(addr, `BLTR_OFF_STS);
    endsequence

    sequence s_ctl_read;
        rd_en && hit(addr, `BLTR_OFF_CTL);
    endsequence

    a_restart_pulse: assert property (
        s_ctl_write(`BLTR_CTL_RESTART) |=> cmd.restart)
        else $error("restart strobe missing");

    a_restart_quiet: assert property (
        s_ctl_clear(`BLTR_CTL_RESTART) |=> !cmd.restart)
        else $error("restart without request");

    a_remote_gated: assert property (
        s_ctl_write(`BLTR_CTL_REM_UPD) |=> cmd.send_remote == $past(cfg_reg[`BLTR_CFG_REM_OVR]))
        else $error("remote update gating wrong");

    a_remote_quiet: assert property (
        s_ctl_clear(`BLTR_CTL_REM_UPD) |=> !cmd.send_remote)
        else $error("remote update without request");

    a_local_gated: assert property (
        s_ctl_write(`BLTR_CTL_LOC_UPD) |=> cmd.apply_local == $past(cfg_reg[`BLTR_CFG_LOC_OVR]))
        else $error("local update gating wrong");

    a_local_quiet: assert property (
        s_ctl_clear(`BLTR_CTL_LOC_UPD) |=> !cmd.apply_local)
        else $error("local update without request");

    a_strobe_clear: assert property (
        !(wr_en && hit(addr, `BLTR_OFF_CTL)) |=> cmd == '0)
        else $error("strobe held without write");

    a_ctl_reads_zero: assert property (
        s_ctl_read |=> rdata == '0)
        else $error("strobe bits read back set");

    a_cfg_store: assert property (
        s_cfg_write |=> cfg_reg == $past(wdata))
        else $error("config write not stored");

    a_cfg_hold: assert property (
        !(wr_en && hit(addr, `BLTR_OFF_CFG)) |=> $stable(cfg_reg))
        else $error("config changed without write");

    a_reserved_kept: assert property (
        s_cfg_write |=> cfg_reg[`BLTR_CFG_RSV_MSB:`BLTR_CFG_RSV_LSB]
            == $past(wdata[`BLTR_CFG_RSV_MSB:`BLTR_CFG_RSV_LSB]))
        else $error("reserved bits not kept");

    a_cfg_readback: assert property (
        s_cfg_read |=> rdata == $past(cfg_reg))
        else $error("config readback lost bits");

    a_remote_level: assert property (
        s_cfg_write |=> ctrl.remote_coef_override_en == $past(wdata[`BLTR_CFG_REM_OVR]))
        else $error("remote override level wrong");

    a_local_level: assert property (
        s_cfg_write |=> ctrl.local_coef_override_en == $past(wdata[`BLTR_CFG_LOC_OVR]))
        else $error("local override level wrong");

    a_ctle_off: assert property (
        ctle_code == `BLTR_CTLE_OFF |-> ctrl.ctle_mode == BLTR_CTLE_DIS)
        else $error("tuning off code misdecoded");

    a_ctle_on: assert property (
        ctle_code == `BLTR_CTLE_ON |-> ctrl.ctle_mode == BLTR_CTLE_EN)
        else $error("tuning on code misdecoded");

    a_ctle_reserved: assert property (
        ctle_code != `BLTR_CTLE_OFF && ctle_code != `BLTR_CTLE_ON |-> ctrl.ctle_mode == BLTR_CTLE_RSV)
        else $error("reserved tuning code misdecoded");

    a_swing_level: assert property (
        s_cfg_write |=> ctrl.swing_high == $past(wdata[`BLTR_CFG_SWING]))
        else $error("swing level wrong");

    a_dfe_off: assert property (
        dfe_code == `BLTR_DFE_OFF |-> ctrl.dfe_mode == BLTR_DFE_DIS)
        else $error("feedback off code misdecoded");

    a_dfe_end: assert property (
        dfe_code == `BLTR_DFE_END |-> ctrl.dfe_mode == BLTR_DFE_AT_END)
        else $error("feedback end code misdecoded");

    a_dfe_steps: assert property (
        dfe_code == `BLTR_DFE_STEPS |-> ctrl.dfe_mode == BLTR_DFE_AFTER_STEPS)
        else $error("feedback steps code misdecoded");

    a_dfe_reserved: assert property (
        dfe_code != `BLTR_DFE_OFF && dfe_code != `BLTR_DFE_END && dfe_code != `BLTR_DFE_STEPS
            |-> ctrl.dfe_mode == BLTR_DFE_RSV)
        else $error("reserved feedback code misdecoded");

    a_max_mode: assert property (
        s_cfg_write |=> ctrl.max_eq_mode == $past(wdata[`BLTR_CFG_MAXM]))
        else $error("max mode level wrong");

    a_max_steps: assert property (
        s_cfg_write |=> ctrl.max_post_steps
            == $past(wdata[`BLTR_CFG_STEP_MSB:`BLTR_CFG_STEP_LSB]))
        else $error("max mode steps misrouted");

    a_ber_write: assert property (
        s_ber_write |=> ctrl.ber_frames == $past(wdata[`BLTR_BER_MSB:0]))
        else $error("measurement length not stored");

    a_ber_hold: assert property (
        !(wr_en && hit(addr, `BLTR_OFF_BER)) |=> $stable(ber_reg))
        else $error("measurement length changed");

    a_ber_read: assert property (
        s_ber_read |=> rdata == 32'($past(ber_reg)))
        else $error("measurement length read wrong");

    a_trained_read: assert property (
        s_sts_read |=> rd_view.rx_trained == $past(sts_view.rx_trained))
        else $error("trained flag read wrong");

    a_lock_read: assert property (
        s_sts_read |=> rd_view.frame_lock == $past(sts_view.frame_lock))
        else $error("frame lock flag read wrong");

    a_running_read: assert property (
        s_sts_read |=> rd_view.running == $past(sts_view.running))
        else $error("running flag read wrong");

    a_failure_read: assert property (
        s_sts_read |=> rd_view.failure == $past(sts_view.failure))
        else $error("failure flag read wrong");

    a_err_read: assert property (
        s_sts_read |=> rd_view.ber_err == $past(sts_view.ber_err))
        else $error("error flag read wrong");

    a_lock_err_read: assert property (
        s_sts_read |=> rd_view.lock_err == $past(sts_view.lock_err))
        else $error("lock error flag read wrong");

    a_ctle_loss_read: assert property (
        s_sts_read |=> rd_view.ctle_lock_loss == $past(sts_view.ctle_lock_loss))
        else $error("tuning lock loss flag read wrong");

    a_ctle_sat_read: assert property (
        s_sts_read |=> rd_view.ctle_tune_err == $past(sts_view.ctle_tune_err))
        else $error("tuning saturation flag read wrong");

    a_status_upper: assert property (
        s_sts_read |=> rdata[31:$bits(bltr_status_t)] == '0)
        else $error("status upper bits set");

    a_status_delay: assert property (
        ##2 sts_reg == $past(status_in, 2))
        else $error("status sync depth wrong");

    a_rdata_idle: assert property (
        !rd_en |=> rdata == '0)
        else $error("read data without strobe");

    a_unmapped_zero: assert property (
        rd_en && !hit(addr, `BLTR_OFF_CFG) && !hit(addr, `BLTR_OFF_CTL)
            && !hit(addr, `BLTR_OFF_STS) && !hit(addr, `BLTR_OFF_BER) |=> rdata == '0)
        else $error("unmapped read not zero");

endmodule : bltr_regs

// ### tb/bltr_train_model.sv
module bltr_train_model
    import bltr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register block side
    input wire bltr_cmd_t cmd,
    input wire logic [7:0] fault,
    output bltr_status_t status,
    output int n_remote,
    output int n_local
);
    timeunit 1ns;
    timeprecision 1ps;

    int run_cnt;

    // Start-up runs 8 cycles, then reports trained and locked plus the chosen faults
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt <= 0;
            status <= '0;
        end else if (cmd.restart) begin
            run_cnt <= 8;
            status <= bltr_status_t'(8'h04);
        end else if (run_cnt == 1) begin
            run_cnt <= 0;
            status <= bltr_status_t'(fault | 8'h03);
        end else if (run_cnt != 0) begin
            run_cnt <= run_cnt - 1;
        end
    end

    // Only pulses that get past the override gate are counted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n_remote <= 0;
            n_local <= 0;
        end else begin
            n_remote <= n_remote + int'(cmd.send_remote);
            n_local <= n_local + int'(cmd.apply_local);
        end
    end
endmodule : bltr_train_model

// ### tb/test_bltr_regs.sv
`include "bltr_params.svh"

module test_bltr_regs
    import bltr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`BLTR_ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata;
    logic [7:0] fault = '0;
    bltr_ctrl_t ctrl;
    bltr_cmd_t cmd;
    bltr_status_t status;
    int n_remote;
    int n_local;
    int miscompares = 0;
    int check_count = 0;
    int cfg_m = 32'h0002_2129;
    logic [15:0] lfsr_state = 16'h566a;
    logic [31:0] d;
    logic [31:0] r;

    bltr_regs DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .ctrl(ctrl), .cmd(cmd), .status_in(status));
    bltr_train_model partner (.clk(clk), .rst_n(rst_n), .cmd(cmd), .fault(fault),
        .status(status), .n_remote(n_remote), .n_local(n_local));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step

    function automatic logic [31:0] rnd();
        lfsr_state = step(step(lfsr_state));
        return {lfsr_state, step(lfsr_state)};
    endfunction : rnd

    // Mode codes outside the defined ones all collapse to the reserved decode
    function automatic logic [26:0] exp_ctrl(input logic [31:0] v);
        logic [1:0] ce;
        logic [1:0] de;
        ce = (v[22:20] == 3'h0) ? 2'h0 : (v[22:20] == 3'h3) ? 2'h1 : 2'h2;
        de = (v[26:24] == 3'h0) ? 2'h0 : (v[26:24] == 3'h2) ? 2'h1 :
            (v[26:24] == 3'h3) ? 2'h2 : 2'h3;
        return {v[31:28], de, v[23], ce, v[17:0]};
    endfunction : exp_ctrl

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask : rd

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // The whole sequence needs a few hundred cycles; this is a wide margin
    initial begin
        #50us;
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`BLTR_OFF_CFG, d);
        chk(d, cfg_m);
        chk(32'({ctrl.max_post_steps, ctrl.max_eq_mode, ctrl.dfe_mode, ctrl.swing_high,
            ctrl.ctle_mode, ctrl.local_coef_override_en, ctrl.remote_coef_override_en,
            ctrl.low_fields}), 32'(exp_ctrl(cfg_m)));
        for (int a = 'hd1; a <= 'hd4; a++) begin
            rd(8'(a), d);
            chk(d, 0);
        end
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            r[22:20] = 3'(i);
            r[26:24] = 3'(i);
            wr(`BLTR_OFF_CFG, r);
            cfg_m = r;
            rd(`BLTR_OFF_CFG, d);
            chk(d, cfg_m);
            chk(32'({ctrl.max_post_steps, ctrl.max_eq_mode, ctrl.dfe_mode, ctrl.swing_high,
                ctrl.ctle_mode, ctrl.local_coef_override_en, ctrl.remote_coef_override_en,
                ctrl.low_fields}), 32'(exp_ctrl(cfg_m)));
            r = rnd();
            wr(`BLTR_OFF_BER, r);
            rd(`BLTR_OFF_BER, d);
            chk(d, {22'h0, r[9:0]});
            chk(32'(ctrl.ber_frames), {22'h0, r[9:0]});
        end
        wr(8'hd7, rnd());
        rd(`BLTR_OFF_CFG, d);
        chk(d, cfg_m);
        $display("test configuration done");
        for (int i = 0; i < 2; i++) begin
            r = cfg_m;
            r[17:16] = 2'(i * 3);
            wr(`BLTR_OFF_CFG, r);
            cfg_m = r;
            wr(`BLTR_OFF_CTL, 32'h0000_0110);
            repeat (2) @(posedge clk);
            chk(n_remote, i);
            chk(n_local, i);
            rd(`BLTR_OFF_CTL, d);
            chk(d, 0);
        end
        $display("test coefficient updates done");
        for (int i = 2; i < 8; i++) begin
            fault <= 8'(1 << i) & 8'hf8;
            wr(`BLTR_OFF_CTL, 32'h0000_0001);
            @(negedge clk);
            chk(32'(cmd.restart), 1);
            @(negedge clk);
            chk(32'(cmd.restart), 0);
            repeat (2) @(posedge clk);
            rd(`BLTR_OFF_STS, d);
            chk(d, 32'h04);
            repeat (12) @(posedge clk);
            rd(`BLTR_OFF_STS, d);
            chk(d, 32'(fault | 8'h03));
        end
        $display("test restart and status done");
        complete_run();
    end
endmodule : test_bltr_regs
